// ---- rtl/irt_timer_pair.sv ----
// Short and long infrared pulse counters with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "irt_map.svh"
module irt_timer_pair
  import irt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port3_line1,
  input  wire logic        port2_line0,
  input  wire logic        port3_line5_port,
  output logic             port3_line5,
  output logic             short_counter_output,
  output logic             long_counter_output,
  output logic             short_timeout_irq,
  output logic             short_capture_irq,
  output logic             long_timeout_irq,
  output logic             long_capture_irq
);

  irt_state_s q;
  irt_state_s d;

  logic [3:0] idx;
  logic       addr_ok;
  logic       wr;
  logic       demod;
  logic       tick8;
  logic       tick16;
  logic       raw_in;
  logic       pos_edge;
  logic       neg_edge;
  logic       start8;
  logic       start16;
  logic       clr8;
  logic       clr16;
  logic       clr_rise;
  logic       clr_fall;
  logic       to8;
  logic       to16;
  logic       new8;
  logic       new16;
  logic [2:0] glen;

  // Address decode
  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) && (idx <= `IRT_IDX_CAP8_NEG);
  assign wr      = psel && penable && pwrite && addr_ok;
  assign demod   = q.func[`IRT_BIT_MODE];

  // Zero wait state slave
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = q.rdata;

  // Count clock enables from the free divider
  function automatic logic sel_tick(input logic [1:0] sel, input logic [2:0] dv);
    case (sel)
      2'h0:    sel_tick = 1'b1;
      2'h1:    sel_tick = dv[0];
      2'h2:    sel_tick = &dv[1:0];
      default: sel_tick = &dv;
    endcase
  endfunction : sel_tick

  assign tick8  = sel_tick(q.ctl8[4:3], q.div);
  assign tick16 = sel_tick(q.ctl16[4:3], q.div);

  // Read data selection
  function automatic logic [7:0] rd_reg(input irt_state_s s, input logic [3:0] i);
    case (i)
      `IRT_IDX_SHORT_CTL:   rd_reg = s.ctl8;
      `IRT_IDX_SHARED_FUNC: rd_reg = s.func;
      `IRT_IDX_LONG_CTL:    rd_reg = s.ctl16;
      `IRT_IDX_SYNC_CTL:    rd_reg = {s.ctl16[7], s.ctl8[7], s.sync_mode, `IRT_SYNC_ONES};
      `IRT_IDX_SHORT_LO:    rd_reg = s.hold8_lo;
      `IRT_IDX_SHORT_HI:    rd_reg = s.hold8_hi;
      `IRT_IDX_LONG_LO:     rd_reg = s.hold16_lo;
      `IRT_IDX_LONG_HI:     rd_reg = s.hold16_hi;
      `IRT_IDX_CAP16_LO:    rd_reg = s.cap16_lo;
      `IRT_IDX_CAP16_HI:    rd_reg = s.cap16_hi;
      `IRT_IDX_CAP8_POS:    rd_reg = s.cap8_pos;
      `IRT_IDX_CAP8_NEG:    rd_reg = s.cap8_neg;
      default:              rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // Next state of the whole block
  always_comb
  begin
    d           = q;
    d.irq8_to   = 1'b0;
    d.irq8_cap  = 1'b0;
    d.irq16_to  = 1'b0;
    d.irq16_cap = 1'b0;
    start8      = 1'b0;
    start16     = 1'b0;
    clr8        = 1'b0;
    clr16       = 1'b0;
    clr_rise    = 1'b0;
    clr_fall    = 1'b0;
    to8         = 1'b0;
    to16        = 1'b0;
    new8        = 1'b0;
    new16       = 1'b0;
    d.div       = q.div + 3'h1;

    // Read data latched in the setup phase
    if (psel && !penable)
    begin
      d.rdata = addr_ok ? {24'h0, rd_reg(q, idx)} : 32'h0;
    end

    // Input select and glitch filter
    raw_in = q.func[`IRT_BIT_IN_SEL] ? port2_line0 : port3_line1;
    glen   = (q.func[3:2] == 2'h1) ? `IRT_GLITCH_SHORT : `IRT_GLITCH_LONG;
    if (!demod || (q.func[3:2] == 2'h0))
    begin
      d.filt       = raw_in;
      d.glitch_cnt = 3'h0;
    end
    else if (raw_in != q.filt)
    begin
      d.glitch_cnt = q.glitch_cnt + 3'h1;
      if (q.glitch_cnt >= glen)
      begin
        d.filt       = raw_in;
        d.glitch_cnt = 3'h0;
      end
    end
    else
    begin
      d.glitch_cnt = 3'h0;
    end
    pos_edge = demod && !q.filt && d.filt && (q.func[5:4] != 2'h0);
    neg_edge = demod && q.filt && !d.filt && ((q.func[5:4] == 2'h0) || (q.func[5:4] == 2'h2));

    // Register writes
    if (wr)
    begin
      case (idx)
        `IRT_IDX_SHORT_CTL:
        begin
          start8 = pwdata[7] && !q.ctl8[7];
          d.ctl8 = {pwdata[7:6], q.ctl8[5], pwdata[4:0]};
          clr8   = pwdata[5];
        end
        `IRT_IDX_SHARED_FUNC:
        begin
          d.func[7:2] = pwdata[7:2];
          if (demod)
          begin
            clr_rise = pwdata[1];
            clr_fall = pwdata[0];
          end
          else
          begin
            d.func[1:0] = pwdata[1:0];
          end
        end
        `IRT_IDX_LONG_CTL:
        begin
          start16 = pwdata[7] && !q.ctl16[7];
          d.ctl16 = {pwdata[7:6], q.ctl16[5], pwdata[4:0]};
          clr16   = pwdata[5];
        end
        `IRT_IDX_SYNC_CTL:
        begin
          start16     = pwdata[7] && !q.ctl16[7];
          start8      = pwdata[6] && !q.ctl8[7];
          d.ctl16[7]  = pwdata[7];
          d.ctl8[7]   = pwdata[6];
          d.sync_mode = pwdata[`IRT_BIT_SYNC];
        end
        `IRT_IDX_SHORT_LO: d.hold8_lo  = pwdata[7:0];
        `IRT_IDX_SHORT_HI: d.hold8_hi  = pwdata[7:0];
        `IRT_IDX_LONG_LO:  d.hold16_lo = pwdata[7:0];
        `IRT_IDX_LONG_HI:  d.hold16_hi = pwdata[7:0];
        default: ;
      endcase
    end

    // Flag clears come first so a same cycle event wins
    if (clr8)
      d.ctl8[`IRT_BIT_TIMEOUT] = 1'b0;
    if (clr16)
      d.ctl16[`IRT_BIT_TIMEOUT] = 1'b0;
    if (clr_rise)
      d.func[`IRT_BIT_INIT8] = 1'b0;
    if (clr_fall)
      d.func[`IRT_BIT_INIT16] = 1'b0;

    // Short counter
    if (!demod)
    begin
      if (start8)
      begin
        d.out8 = q.func[`IRT_BIT_INIT8];
        d.cnt8 = q.func[`IRT_BIT_INIT8] ? q.hold8_hi : q.hold8_lo;
      end
      else if (q.ctl8[7] && tick8)
      begin
        if (q.cnt8 == 8'h01)
        begin
          new8   = !q.out8;
          d.out8 = new8;
          if (q.ctl8[`IRT_BIT_SINGLE])
          begin
            d.ctl8[7] = 1'b0;
            d.cnt8    = 8'h00;
            to8       = 1'b1;
          end
          else
          begin
            d.cnt8 = new8 ? q.hold8_hi : q.hold8_lo;
            to8    = (new8 == q.func[`IRT_BIT_INIT8]);
          end
        end
        else
        begin
          d.cnt8 = q.cnt8 - 8'h01;
        end
      end
    end
    else
    begin
      if (start8)
        d.run8 = 1'b0;
      else if (q.ctl8[7] && (pos_edge || neg_edge))
      begin
        d.cnt8 = 8'hFF;
        d.run8 = 1'b1;
        if (q.run8)
        begin
          if (pos_edge)
          begin
            d.cap8_pos             = ~q.cnt8;
            d.func[`IRT_BIT_INIT8] = 1'b1;
          end
          else
          begin
            d.cap8_neg              = ~q.cnt8;
            d.func[`IRT_BIT_INIT16] = 1'b1;
          end
          d.irq8_cap = q.ctl8[`IRT_BIT_CAP_MASK];
        end
      end
      else if (q.ctl8[7] && q.run8 && tick8)
      begin
        d.cnt8 = q.cnt8 - 8'h01;
        to8    = (q.cnt8 == 8'h01);
      end
    end
    if (to8)
    begin
      d.ctl8[`IRT_BIT_TIMEOUT] = 1'b1;
      d.irq8_to                = q.ctl8[`IRT_BIT_TO_MASK];
    end

    // Long counter
    if (!demod)
    begin
      if (start16)
      begin
        d.out16 = q.func[`IRT_BIT_INIT16];
        d.cnt16 = {q.hold16_hi, q.hold16_lo};
      end
      else if (q.ctl16[7] && tick16)
      begin
        if (q.cnt16 == 16'h0001)
        begin
          new16   = !q.out16;
          d.out16 = new16;
          to16    = 1'b1;
          if (q.ctl16[`IRT_BIT_SINGLE])
          begin
            d.ctl16[7] = 1'b0;
            d.cnt16    = 16'h0000;
          end
          else
          begin
            d.cnt16 = {q.hold16_hi, q.hold16_lo};
          end
        end
        else
        begin
          d.cnt16 = q.cnt16 - 16'h0001;
        end
      end
    end
    else
    begin
      if (start16)
        d.run16 = 1'b0;
      else if (q.ctl16[7] && (pos_edge || neg_edge) &&
               (!q.run16 || !q.ctl16[`IRT_BIT_SINGLE]))
      begin
        d.cap16_hi  = ~q.cnt16[15:8];
        d.cap16_lo  = ~q.cnt16[7:0];
        d.cnt16     = {q.hold16_hi, q.hold16_lo};
        d.run16     = 1'b1;
        d.irq16_cap = q.ctl16[`IRT_BIT_CAP_MASK];
        if (q.run16)
        begin
          if (pos_edge)
            d.func[`IRT_BIT_INIT8] = 1'b1;
          else
            d.func[`IRT_BIT_INIT16] = 1'b1;
        end
      end
      else if (q.ctl16[7] && q.run16 && tick16)
      begin
        d.cnt16 = q.cnt16 - 16'h0001;
        to16    = (q.cnt16 == 16'h0001);
      end
    end
    if (to16)
    begin
      d.ctl16[`IRT_BIT_TIMEOUT] = 1'b1;
      d.irq16_to                = q.ctl16[`IRT_BIT_TO_MASK];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q           <= '0;
      q.ctl8      <= `IRT_RST_CTL;
      q.func      <= `IRT_RST_CTL;
      q.ctl16     <= `IRT_RST_CTL;
      q.hold8_lo  <= `IRT_RST_HOLD;
      q.hold8_hi  <= `IRT_RST_HOLD;
      q.hold16_lo <= `IRT_RST_HOLD;
      q.hold16_hi <= `IRT_RST_HOLD;
    end
    else
    begin
      q <= d;
    end
  end

  // Pin level outputs
  assign short_counter_output = q.ctl8[7] ? q.out8 : !q.func[`IRT_BIT_INIT8];
  assign long_counter_output  = (!demod && q.func[3]) ? q.func[2] :
                                (q.ctl16[7] ? q.out16 : !q.func[`IRT_BIT_INIT16]);
  assign port3_line5 = q.ctl16[`IRT_BIT_PIN_OUT] ? long_counter_output : port3_line5_port;
  assign short_timeout_irq    = q.irq8_to;
  assign short_capture_irq    = q.irq8_cap;
  assign long_timeout_irq     = q.irq16_to;
  assign long_capture_irq     = q.irq16_cap;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_short_idle;
    !q.ctl8[7] |-> short_counter_output == !q.func[`IRT_BIT_INIT8];
  endproperty
  a_short_idle: assert property (p_short_idle) else $error("short idle level wrong");

  property p_short_start;
    (wr && idx == `IRT_IDX_SHORT_CTL && pwdata[7] && !q.ctl8[7] && !demod) |=>
      (short_counter_output == $past(q.func[1])) &&
      (q.cnt8 == ($past(q.func[1]) ? $past(q.hold8_hi) : $past(q.hold8_lo)));
  endproperty
  a_short_start: assert property (p_short_start) else $error("short start load wrong");

  property p_rise_flag;
    (pos_edge && q.ctl8[7] && q.run8) |=> q.func[`IRT_BIT_INIT8];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising flag not set");

  property p_long_stop;
    (wr && idx == `IRT_IDX_LONG_CTL && !pwdata[7]) |=> !q.ctl16[7];
  endproperty
  a_long_stop: assert property (p_long_stop) else $error("long stop ignored");

  property p_long_tc_flag;
    (!demod && q.ctl16[7] && tick16 && q.cnt16 == 16'h0001) |=>
      q.ctl16[`IRT_BIT_TIMEOUT] && (q.out16 != $past(q.out16));
  endproperty
  a_long_tc_flag: assert property (p_long_tc_flag) else $error("long timeout missing");

  property p_div8;
    (tick16 && q.ctl16[4:3] == 2'h3) |=>
      (!tick16 || q.ctl16[4:3] != 2'h3) [*7] ##1 (tick16 || q.ctl16[4:3] != 2'h3);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight wrong");

  property p_sync_read;
    (psel && penable && addr_ok && idx == `IRT_IDX_SYNC_CTL) |->
      prdata[4:0] == 5'h1F && prdata[7] == $past(q.ctl16[7]) &&
      prdata[6] == $past(q.ctl8[7]);
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync read wrong");

  property p_pin_route;
    port3_line5 == (q.ctl16[0] ? long_counter_output : port3_line5_port);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin route wrong");

  property p_zero_wrap;
    (!demod && q.ctl8[7] && tick8 && q.cnt8 == 8'h00 && !start8) |=>
      q.cnt8 == 8'hFF && !q.irq8_to;
  endproperty
  a_zero_wrap: assert property (p_zero_wrap) else $error("zero wrap wrong");

  property p_forced;
    (!demod && q.func[3:2] == 2'h2) |-> !long_counter_output;
  endproperty
  a_forced: assert property (p_forced) else $error("forced low wrong");

  c_short_to:  cover property (q.irq8_to);
  c_long_cap:  cover property (q.irq16_cap);
  c_sync_read: cover property (psel && penable && idx == `IRT_IDX_SYNC_CTL);
  c_edge:      cover property (pos_edge ##[1:50] neg_edge);

endmodule : irt_timer_pair

// ---- pkg/irt_map.svh ----
// Register map, field positions and reset values of the pulse timer pair
`ifndef IRT_MAP_SVH
`define IRT_MAP_SVH
// Register indices; byte address is four times the index
`define IRT_IDX_SHORT_CTL    4'h0
`define IRT_IDX_SHARED_FUNC  4'h1
`define IRT_IDX_LONG_CTL     4'h2
`define IRT_IDX_SYNC_CTL     4'h3
`define IRT_IDX_SHORT_LO     4'h4
`define IRT_IDX_SHORT_HI     4'h5
`define IRT_IDX_LONG_LO      4'h6
`define IRT_IDX_LONG_HI      4'h7
`define IRT_IDX_CAP16_LO     4'h8
`define IRT_IDX_CAP16_HI     4'h9
`define IRT_IDX_CAP8_POS     4'hA
`define IRT_IDX_CAP8_NEG     4'hB
// Control field positions
`define IRT_BIT_ENABLE       7
`define IRT_BIT_SINGLE       6
`define IRT_BIT_TIMEOUT      5
`define IRT_BIT_CAP_MASK     2
`define IRT_BIT_TO_MASK      1
`define IRT_BIT_PIN_OUT      0
`define IRT_BIT_MODE         7
`define IRT_BIT_IN_SEL       6
`define IRT_BIT_INIT8        1
`define IRT_BIT_INIT16       0
`define IRT_BIT_SYNC         5
// Reset values and constant read bits
`define IRT_RST_CTL          8'h00
`define IRT_RST_HOLD         8'h00
`define IRT_SYNC_ONES        5'h1F
// Glitch filter widths in clock cycles
`define IRT_GLITCH_SHORT     3'h3
`define IRT_GLITCH_LONG      3'h7
`endif

// ---- pkg/irt_pkg.sv ----
// Types shared by the pulse timer pair
package irt_pkg;
  typedef struct packed {
    logic [7:0]  ctl8;
    logic [7:0]  func;
    logic [7:0]  ctl16;
    logic        sync_mode;
    logic [7:0]  hold8_lo;
    logic [7:0]  hold8_hi;
    logic [7:0]  hold16_lo;
    logic [7:0]  hold16_hi;
    logic [7:0]  cap8_pos;
    logic [7:0]  cap8_neg;
    logic [7:0]  cap16_lo;
    logic [7:0]  cap16_hi;
    logic [7:0]  cnt8;
    logic [15:0] cnt16;
    logic        out8;
    logic        out16;
    logic        run8;
    logic        run16;
    logic [2:0]  div;
    logic        filt;
    logic [2:0]  glitch_cnt;
    logic        irq8_to;
    logic        irq8_cap;
    logic        irq16_to;
    logic        irq16_cap;
    logic [31:0] rdata;
  } irt_state_s;
endpackage : irt_pkg

// ---- test/irt_ir_link.sv ----
// Far-side infrared link model driving the demodulator input pins
`timescale 1ns/1ns
module irt_ir_link
(
  input  wire logic pclk,
  output logic      port3_line1,
  output logic      port2_line0
);
  logic line_q  = 1'b0;
  logic noise_q = 1'b0;
  // Unselected pin chatters every cycle so a wrong input select shows up
  always @(posedge pclk)
  begin
    noise_q <= ~noise_q;
  end
  assign port3_line1 = line_q;
  assign port2_line0 = noise_q;
  // Hold the pulse level for a number of clock cycles
  task automatic hold(input logic lvl, input int cyc);
    @(posedge pclk);
    line_q <= lvl;
    repeat (cyc - 1) @(posedge pclk);
  endtask : hold
endmodule : irt_ir_link

// ---- test/test_infrared_pulse_timer_pair.sv ----
// Self-checking bench for the infrared pulse timer pair
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module test_infrared_pulse_timer_pair
  import irt_pkg::*;
;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} irt_exp_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, port3_line5_port = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  v, a;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, port3_line1, port2_line0, port3_line5;
  logic        short_counter_output, long_counter_output;
  logic        short_timeout_irq, short_capture_irq, long_timeout_irq, long_capture_irq;
  int          err_total = 0, samples_checked = 0, seed = 5, n, c0, c1;
  int          cap_s = 0, cap_l = 0, to_s = 0;
  irt_exp_s    q[$];
  irt_exp_s    x;

  always #5 pclk = ~pclk;

  irt_timer_pair DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port3_line1(port3_line1), .port2_line0(port2_line0),
    .port3_line5_port(port3_line5_port), .port3_line5(port3_line5),
    .short_counter_output(short_counter_output), .long_counter_output(long_counter_output),
    .short_timeout_irq(short_timeout_irq), .short_capture_irq(short_capture_irq),
    .long_timeout_irq(long_timeout_irq), .long_capture_irq(long_capture_irq));

  irt_ir_link link (.pclk(pclk), .port3_line1(port3_line1), .port2_line0(port2_line0));

  // Interrupt pulse tallies
  always @(posedge pclk)
  begin
    cap_s <= cap_s + int'(short_capture_irq);
    cap_l <= cap_l + int'(long_capture_irq);
    to_s  <= to_s + int'(short_timeout_irq);
  end

  // Read monitor: oldest note against each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      if (q.size() == 0) `CHK("queue", 1'b1, 1'b0)
      else
      begin
        x = q.pop_front();
        `CHK("prdata", x.d, prdata & x.m)
        `CHK("pslverr", x.e, pslverr)
      end
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // One APB transfer; read expectations are queued for the monitor
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d, input irt_exp_s e);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) q.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge pclk);
    end
    if (k == 20) begin err_total++; final_report(); end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d, '0);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    apb(1'b0, ad, 8'h00, irt_exp_s'{{24'h0, e & m}, {24'hFF_FFFF, m}, 1'b0});
  endtask : rd

  // Edges until an output reaches a level: 0 long out, 1 short out, 2/3 short/long timeout
  task automatic count_to(input int b, input logic lvl, output int c);
    logic [3:0] w;
    c = 0;
    do
    begin
      @(posedge pclk);
      #1;
      c++;
      w = {long_timeout_irq, short_timeout_irq, short_counter_output, long_counter_output};
    end while (w[b] !== lvl && c < 600);
    if (c == 600) begin err_total++; final_report(); end
  endtask : count_to

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    `CHK("short_out", 1'b1, short_counter_output)
    `CHK("long_out", 1'b1, long_counter_output)
    presetn <= 1'b1;
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h1F);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h1F);
    apb(1'b0, 8'h30, 8'h00, irt_exp_s'{32'h0, 32'hFFFF_FFFF, 1'b1});
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      a = 8'h10 + 8'(i * 4);
      wr(a, v);
      rd(a, v);
      port3_line5_port <= v[0];
      @(posedge pclk);
      #1 `CHK("pin", v[0], port3_line5)
    end
    tdone("reset_regs");
    // Long single pass at every count clock
    wr(8'h18, 8'h03);
    wr(8'h1C, 8'h00);
    wr(8'h04, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h08, 8'hC3 | 8'(s << 3));
      #1 `CHK("long_start", 1'b1, long_counter_output)
      `CHK("pin_route", long_counter_output, port3_line5)
      count_to(3, 1'b1, n);
      `CHK("ticks", 1'b1, n >= (2 << s) + 1 && n <= (3 << s))
      rd(8'h08, 8'h63 | 8'(s << 3));
      wr(8'h08, 8'h20);
      rd(8'h08, 8'h00);
    end
    tdone("long_single");
    wr(8'h18, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h82);
    #1 `CHK("long_start", 1'b0, long_counter_output)
    `CHK("pin_port", port3_line5_port, port3_line5)
    count_to(3, 1'b1, n);
    `CHK("first", 4, n)
    count_to(3, 1'b1, n);
    `CHK("reload", 4, n)
    rd(8'h0C, 8'h9F);
    wr(8'h08, 8'h00);
    wr(8'h08, 8'h20);
    rd(8'h08, 8'h00);
    tdone("long_modulo");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, i == 0 ? 8'h00 : i == 1 ? 8'h03 : i == 2 ? 8'h08 : 8'h0E);
      #1 `CHK("long_idle", 4'b1001 >> i & 1'b1, long_counter_output)
      `CHK("short_idle", 4'b0101 >> i & 1'b1, short_counter_output)
    end
    wr(8'h04, 8'h08);
    wr(8'h08, 8'h80);
    #1 `CHK("forced", 1'b0, long_counter_output)
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    tdone("idle_levels");
    // Short modulo-N: two phases, one timeout per cycle
    wr(8'h10, 8'h02);
    wr(8'h14, 8'h05);
    wr(8'h00, 8'h82);
    #1 `CHK("short_start", 1'b0, short_counter_output)
    count_to(1, 1'b1, n);
    `CHK("low_phase", 2, n)
    `CHK("no_irq", 1'b0, short_timeout_irq)
    count_to(2, 1'b1, n);
    `CHK("high_phase", 5, n)
    `CHK("toggle", 1'b0, short_counter_output)
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'hC0);
    c0 = to_s;
    repeat (10) @(posedge pclk);
    `CHK("masked", c0, to_s)
    rd(8'h00, 8'h60);
    wr(8'h00, 8'h20);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h82);
    c0 = to_s;
    repeat (200) @(posedge pclk);
    `CHK("wrap_irq", c0, to_s)
    `CHK("wrap_out", 1'b0, short_counter_output)
    wr(8'h00, 8'h00);
    tdone("short_transmit");
    // Demodulation of a pulse train with a glitch
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i * 4), 8'hFF);
    wr(8'h04, 8'hA4);
    wr(8'h00, 8'h86);
    wr(8'h08, 8'hC4);
    c0 = cap_s;
    c1 = cap_l;
    link.hold(1'b1, 19);
    link.hold(1'b0, 19);
    link.hold(1'b1, 19);
    link.hold(1'b0, 2);
    link.hold(1'b1, 30);
    `CHK("short_caps", 2, cap_s - c0)
    `CHK("long_caps", 1, cap_l - c1)
    rd(8'h2C, 8'h12, 8'hFE);
    rd(8'h28, 8'h12, 8'hFE);
    rd(8'h04, 8'hA7);
    wr(8'h04, 8'hA6);
    rd(8'h04, 8'hA5);
    count_to(2, 1'b1, n);
    `CHK("demod_to", 1'b1, n < 300)
    rd(8'h00, 8'hA6);
    // Second pin selected: its chatter is filtered, the first pin is ignored
    wr(8'h04, 8'hE4);
    c0 = cap_s;
    link.hold(1'b0, 40);
    `CHK("sel_noise", c0, cap_s)
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h00);
    tdone("demod");
    final_report();
  end
endmodule : test_infrared_pulse_timer_pair
